/* rtl/bit_band_defs.vh */
// address map and field constants for the bit-band alias remapper
`ifndef BIT_BAND_DEFS_VH
`define BIT_BAND_DEFS_VH
`define BB_SRAM_DIR_LO    32'h20000000
`define BB_SRAM_DIR_HI    32'h20007FFF
`define BB_PERI_DIR_LO    32'h40000000
`define BB_PERI_DIR_HI    32'h400FFFFF
`define BB_SRAM_ALIAS_LO  32'h22000000
`define BB_SRAM_ALIAS_HI  32'h220FFFFF
`define BB_PERI_ALIAS_LO  32'h42000000
`define BB_PERI_ALIAS_HI  32'h43FFFFFF
`define BB_SRAM_BAND_BASE 32'h20000000
`define BB_PERI_BAND_BASE 32'h40000000
`define BB_SIZE_BYTE      2'h0
`define BB_SIZE_HALF      2'h1
`define BB_SIZE_WORD      2'h2
`endif

/* rtl/bit_band_decode.v */
// alias address decoder: window hit and target byte address and bit number
`default_nettype none
module bit_band_decode
(
    input  wire [31:0] addr_i,
    input  wire        fetch_i,
    output reg         alias_o,
    output reg         fault_o,
    output reg  [31:0] tgt_addr_o,
    output reg  [2:0]  bit_o
);
`include "bit_band_defs.vh"
    reg in_sram;
    reg in_peri;
    always @*
    begin
        in_sram = (addr_i >= `BB_SRAM_ALIAS_LO) && (addr_i <= `BB_SRAM_ALIAS_HI);
        in_peri = (addr_i >= `BB_PERI_ALIAS_LO) && (addr_i <= `BB_PERI_ALIAS_HI);
        // data accesses remap; sram fetches pass; peripheral fetches fault
        alias_o = (in_sram || in_peri) && !fetch_i;
        fault_o = in_peri && fetch_i;
        // offset = byte*32 + bit*4
        bit_o = addr_i[4:2];
        tgt_addr_o = (in_peri ? `BB_PERI_BAND_BASE : `BB_SRAM_BAND_BASE) | {12'h000, addr_i[24:5]};
    end
endmodule // bit_band_decode
`default_nettype wire

/* rtl/bit_band_alias_remapper.v */
// bit-band alias remapper between a bus master and its slaves
`default_nettype none
module bit_band_alias_remapper
(
    input  wire        MCLK_I,
    input  wire        RST_I,
    input  wire        M_REQ_I,
    input  wire        M_WRITE_I,
    input  wire        M_FETCH_I,
    input  wire [1:0]  M_SIZE_I,
    input  wire [31:0] M_ADDR_I,
    input  wire [31:0] M_WDATA_I,
    output reg         M_DONE_O,
    output reg         M_ERR_O,
    output reg  [31:0] M_RDATA_O,
    output reg         S_REQ_O,
    output reg         S_WRITE_O,
    output reg  [1:0]  S_SIZE_O,
    output reg  [31:0] S_ADDR_O,
    output reg  [31:0] S_WDATA_O,
    input  wire        S_DONE_I,
    input  wire [31:0] S_RDATA_I
);
`include "bit_band_defs.vh"
    localparam [4:0] ST_IDLE = 5'h01;
    localparam [4:0] ST_PASS = 5'h02;
    localparam [4:0] ST_RD   = 5'h04;
    localparam [4:0] ST_WB   = 5'h08;
    localparam [4:0] ST_RESP = 5'h10;

    wire        dec_alias;
    wire        dec_fault;
    wire [31:0] dec_addr;
    wire [2:0]  dec_bit;

    reg  [4:0]  state_q;
    reg  [4:0]  state_d;
    reg         wr_q;
    reg         wbit_q;
    reg  [4:0]  pos_q;
    reg         s_req_d;
    reg         s_write_d;
    reg  [1:0]  s_size_d;
    reg  [31:0] s_addr_d;
    reg  [31:0] s_wdata_d;
    reg         done_d;
    reg         err_d;
    reg  [31:0] rdata_d;
    reg  [31:0] merged;
    reg  [4:0]  pos_d;

    bit_band_decode u_dec
    (
        .addr_i     (M_ADDR_I),
        .fetch_i    (M_FETCH_I),
        .alias_o    (dec_alias),
        .fault_o    (dec_fault),
        .tgt_addr_o (dec_addr),
        .bit_o      (dec_bit)
    );

    always @*
    begin
        state_d   = state_q;
        s_req_d   = S_REQ_O;
        s_write_d = S_WRITE_O;
        s_size_d  = S_SIZE_O;
        s_addr_d  = S_ADDR_O;
        s_wdata_d = S_WDATA_O;
        done_d    = 1'b0;
        err_d     = 1'b0;
        rdata_d   = M_RDATA_O;
        pos_d     = pos_q;
        merged    = S_RDATA_I;
        // bit lane within the word, little-endian byte order
        merged[pos_q] = wbit_q;
        case (state_q)
            ST_IDLE:
            begin
                if (M_REQ_I && dec_fault)
                begin
                    done_d  = 1'b1;
                    err_d   = 1'b1;
                    rdata_d = 32'h00000000;
                end
                else if (M_REQ_I && dec_alias)
                begin
                    // underlying address aligned to the request size
                    s_req_d   = 1'b1;
                    s_write_d = 1'b0;
                    s_size_d  = M_SIZE_I;
                    if (M_SIZE_I == `BB_SIZE_WORD)
                    begin
                        s_addr_d = {dec_addr[31:2], 2'h0};
                        pos_d    = {dec_addr[1:0], dec_bit};
                    end
                    else if (M_SIZE_I == `BB_SIZE_HALF)
                    begin
                        s_addr_d = {dec_addr[31:1], 1'h0};
                        pos_d    = {dec_addr[1:0], dec_bit};
                    end
                    else
                    begin
                        s_addr_d = dec_addr;
                        pos_d    = {dec_addr[1:0], dec_bit};
                    end
                    state_d = ST_RD;
                end
                else if (M_REQ_I)
                begin
                    // straight through: direct band ranges and everything else
                    s_req_d   = 1'b1;
                    s_write_d = M_WRITE_I;
                    s_size_d  = M_SIZE_I;
                    s_addr_d  = M_ADDR_I;
                    s_wdata_d = M_WDATA_I;
                    state_d   = ST_PASS;
                end
            end
            ST_PASS:
            begin
                if (S_DONE_I)
                begin
                    s_req_d = 1'b0;
                    done_d  = 1'b1;
                    rdata_d = S_RDATA_I;
                    state_d = ST_IDLE;
                end
            end
            ST_RD:
            begin
                if (S_DONE_I)
                begin
                    if (wr_q)
                    begin
                        // write back with only the target bit changed
                        s_write_d = 1'b1;
                        s_wdata_d = merged;
                        state_d   = ST_WB;
                    end
                    else
                    begin
                        s_req_d = 1'b0;
                        done_d  = 1'b1;
                        rdata_d = {31'h00000000, S_RDATA_I[pos_q]};
                        state_d = ST_IDLE;
                    end
                end
            end
            ST_WB:
            begin
                if (S_DONE_I)
                begin
                    s_req_d   = 1'b0;
                    s_write_d = 1'b0;
                    state_d   = ST_RESP;
                end
            end
            ST_RESP:
            begin
                done_d  = 1'b1;
                rdata_d = 32'h00000000;
                state_d = ST_IDLE;
            end
            default:
            begin
                state_d = ST_IDLE;
                s_req_d = 1'b0;
            end
        endcase
    end

    always @(posedge MCLK_I or posedge RST_I)
    begin
        if (RST_I)
        begin
            state_q   <= ST_IDLE;
            wr_q      <= 1'b0;
            wbit_q    <= 1'b0;
            pos_q     <= 5'h00;
            S_REQ_O   <= 1'b0;
            S_WRITE_O <= 1'b0;
            S_SIZE_O  <= 2'h0;
            S_ADDR_O  <= 32'h00000000;
            S_WDATA_O <= 32'h00000000;
            M_DONE_O  <= 1'b0;
            M_ERR_O   <= 1'b0;
            M_RDATA_O <= 32'h00000000;
        end
        else
        begin
            state_q   <= state_d;
            pos_q     <= pos_d;
            S_REQ_O   <= s_req_d;
            S_WRITE_O <= s_write_d;
            S_SIZE_O  <= s_size_d;
            S_ADDR_O  <= s_addr_d;
            S_WDATA_O <= s_wdata_d;
            M_DONE_O  <= done_d;
            M_ERR_O   <= err_d;
            M_RDATA_O <= rdata_d;
            if (state_q == ST_IDLE && M_REQ_I)
            begin
                wr_q   <= M_WRITE_I;
                wbit_q <= M_WDATA_I[0];
            end
        end
    end
endmodule // bit_band_alias_remapper
`default_nettype wire

/* bench/bb_chk_asserts.sv */
// port checker for the bit-band remapper
`default_nettype none
module bb_chk(
    input wire logic MCLK_I, RST_I, M_REQ_I, M_WRITE_I, M_FETCH_I, M_DONE_O, M_ERR_O, S_REQ_O, S_WRITE_O, S_DONE_I,
    input wire logic [1:0] M_SIZE_I, S_SIZE_O,
    input wire logic [31:0] M_ADDR_I, M_WDATA_I, M_RDATA_O, S_ADDR_O, S_WDATA_O, S_RDATA_I);
    timeunit 1ns;
    timeprecision 1ps;
    logic bsy_q, al_q, wr_q, b0_q;
    logic [4:0] pos_q;
    wire tk = M_REQ_I && (!bsy_q || M_DONE_O);
    wire ps = M_ADDR_I[31:25] == 7'h21;
    wire al = !M_FETCH_I && (ps || M_ADDR_I[31:20] == 12'h220);
    always @(posedge MCLK_I or posedge RST_I)
        if (RST_I) {bsy_q, al_q, wr_q, b0_q, pos_q} <= '0;
        else if (tk) {bsy_q, al_q, wr_q, b0_q, pos_q} <= {1'b1, al, M_WRITE_I, M_WDATA_I[0], M_ADDR_I[6:2]};
        else if (M_DONE_O) bsy_q <= 1'b0;
    default clocking @(posedge MCLK_I); endclocking
    default disable iff (RST_I);
    AST_ERR_DONE: assert property (M_ERR_O |-> M_DONE_O) else $error("error without done");
    AST_FETCH_REJ: assert property (tk && M_FETCH_I && ps |=> M_DONE_O && M_ERR_O && !S_REQ_O)
        else $error("fetch not rejected");
    AST_PASS: assert property (tk && !al && !(M_FETCH_I && ps) |=> S_REQ_O
        && S_ADDR_O == $past(M_ADDR_I) && S_SIZE_O == $past(M_SIZE_I)
        && S_WRITE_O == $past(M_WRITE_I) && S_WDATA_O == $past(M_WDATA_I)) else $error("pass changed");
    AST_AL_ADDR: assert property (tk && al |=> S_REQ_O && !S_WRITE_O && S_SIZE_O == $past(M_SIZE_I)
        && S_ADDR_O[19:2] == $past(M_ADDR_I[24:7]) && S_ADDR_O[31:20] == ($past(ps) ? 12'h400 : 12'h200))
        else $error("alias target");
    AST_RMW: assert property (al_q && wr_q && S_REQ_O && !S_WRITE_O && S_DONE_I |=>
        S_REQ_O && S_WRITE_O && $stable(S_ADDR_O)) else $error("no write back");
    AST_MERGE: assert property (al_q && S_REQ_O && S_WRITE_O |-> S_WDATA_O[pos_q] == b0_q)
        else $error("bad merged bit");
    AST_WB_DONE: assert property (al_q && S_WRITE_O && S_DONE_I |-> ##2 M_DONE_O) else $error("late done");
    AST_RD_BIT: assert property (M_DONE_O && al_q |-> M_RDATA_O[31:1] == 31'h0) else $error("alias data");
    AST_PASS_DONE: assert property (S_DONE_I && S_REQ_O && !al_q |=> M_DONE_O && !S_REQ_O
        && M_RDATA_O == $past(S_RDATA_I)) else $error("pass answer");
endmodule // bb_chk
bind bit_band_alias_remapper bb_chk u_chk (.*);
`default_nettype wire

/* bench/slave_mem.sv */
// slave memory model with adjustable latency
`default_nettype none
module slave_mem(
    input wire logic clk_i, req_i, write_i,
    input wire logic [1:0] size_i,
    input wire logic [3:0] lag_i,
    input wire logic [31:0] addr_i, wdata_i,
    output logic done_o,
    output logic [31:0] rdata_o);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [logic [31:0]];
    logic [31:0] k, w;
    logic [3:0] cnt = 0;
    initial {done_o, rdata_o} = '0;
    always @(posedge clk_i)
    begin
        done_o <= 1'b0;
        rdata_o <= ~rdata_o; // data not held after done
        cnt <= 0;
        if (req_i && !done_o)
            if (cnt < lag_i) cnt <= cnt + 1;
            else
            begin
                k = {addr_i[31:2], 2'h0};
                w = mem.exists(k) ? mem[k] : '0;
                for (int i = 0; i < 4; i++)
                    if (write_i && (size_i == 2'h2 || (size_i == 2'h1 && i[1] == addr_i[1]) || i == addr_i[1:0]))
                        w[8*i+:8] = wdata_i[8*i+:8];
                mem[k] = w;
                rdata_o <= w;
                done_o <= 1'b1;
            end
    end
endmodule // slave_mem
`default_nettype wire

/* bench/testbench.sv */
// testbench for the bit-band remapper
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct {logic w, f; logic [1:0] sz; logic [31:0] a, d, x; logic e;} row_t;
    logic MCLK_I = 0, RST_I = 1, M_REQ_I = 0, M_WRITE_I = 0, M_FETCH_I = 0, S_DONE_I;
    logic M_DONE_O, M_ERR_O, S_REQ_O, S_WRITE_O;
    logic [1:0] M_SIZE_I = 0, S_SIZE_O;
    logic [31:0] M_ADDR_I = 0, M_WDATA_I = 0, M_RDATA_O, S_ADDR_O, S_WDATA_O, S_RDATA_I;
    logic [3:0] lag = 0;
    int bad_count = 0, total_checks = 0;
    row_t rows[17] = '{
        '{0, 0, 2'h2, 32'h20000000, 0, 32'hA5, 0}, '{0, 0, 2'h2, 32'h22000000, 0, 1, 0},
        '{0, 0, 2'h2, 32'h22000004, 0, 0, 0}, '{1, 0, 2'h2, 32'h2200001C, 32'h0E, 0, 0},
        '{0, 0, 2'h2, 32'h20000000, 0, 32'h25, 0}, '{1, 0, 2'h0, 32'h22000024, 32'hFF, 0, 0},
        '{0, 0, 2'h2, 32'h20000000, 0, 32'h225, 0}, '{0, 0, 2'h1, 32'h4200008C, 0, 1, 0},
        '{1, 0, 2'h2, 32'h43FFFFFC, 1, 0, 0}, '{0, 0, 2'h2, 32'h400FFFFC, 0, 32'h80000000, 0},
        '{0, 1, 2'h2, 32'h42000000, 0, 0, 1}, '{0, 1, 2'h2, 32'h22000000, 0, 32'hCAFEF00D, 0},
        '{0, 0, 2'h2, 32'h22100000, 0, 32'h0BADBEEF, 0}, '{1, 0, 2'h1, 32'h22000028, 32'h1, 0, 0},
        '{0, 0, 2'h0, 32'h22000028, 0, 1, 0}, '{0, 0, 2'h2, 32'h20000000, 0, 32'h625, 0},
        '{1, 0, 2'h2, 32'h20000004, 32'h89ABCDEF, 32'h89ABCDEF, 0}};
    always #2.5 MCLK_I = ~MCLK_I;
    bit_band_alias_remapper DUT (.*);
    slave_mem u_mem (.clk_i(MCLK_I), .req_i(S_REQ_O), .write_i(S_WRITE_O), .size_i(S_SIZE_O), .lag_i(lag),
        .addr_i(S_ADDR_O), .wdata_i(S_WDATA_O), .done_o(S_DONE_I), .rdata_o(S_RDATA_I));
    task check(input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task complete_run;
        $display("checks=%0d errors=%0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task op(input row_t r);
        int n;
        n = 0;
        @(posedge MCLK_I);
        #1 {M_WRITE_I, M_FETCH_I, M_SIZE_I, M_ADDR_I, M_WDATA_I} = {r.w, r.f, r.sz, r.a, r.d};
        M_REQ_I = 1;
        do begin @(posedge MCLK_I); #1 n++; end while (M_DONE_O !== 1'b1 && n < 60);
        M_REQ_I = 0;
        if (n == 60) bad_count++;
    endtask
    initial
    begin
        #10000 bad_count++;
        complete_run;
    end
    initial
    begin
        u_mem.mem[32'h20000000] = 32'hA5;
        u_mem.mem[32'h40000004] = 32'h12345678;
        u_mem.mem[32'h22000000] = 32'hCAFEF00D;
        u_mem.mem[32'h22100000] = 32'h0BADBEEF;
        repeat (2) @(posedge MCLK_I);
        #1 RST_I = 0;
        foreach (rows[i])
        begin
            lag = i % 3;
            op(rows[i]);
            check(M_RDATA_O, rows[i].x);
            check(M_ERR_O, rows[i].e);
        end
        lag = 8;
        @(posedge MCLK_I);
        #1 {M_WRITE_I, M_SIZE_I, M_ADDR_I, M_WDATA_I} = {1'b1, 2'h2, 32'h22000000, 32'h0};
        M_REQ_I = 1;
        @(posedge MCLK_I);
        #1 M_REQ_I = 0;
        @(posedge MCLK_I);
        #1 RST_I = 1;
        #1 check({S_REQ_O, S_WRITE_O, M_DONE_O, M_ERR_O}, 0);
        check(M_RDATA_O, 0);
        @(posedge MCLK_I);
        #1 RST_I = 0;
        lag = 0;
        op(rows[1]);
        check(M_RDATA_O, 1);
        complete_run;
    end
endmodule // testbench
`default_nettype wire
